/* ptrd_consts.svh */
// Constants for the clock-control register block: register indices,
// field positions, write masks and reset values.
// Assumes inclusion by its bare name from every design file that needs it.
`ifndef PTRD_CONSTS_SVH
`define PTRD_CONSTS_SVH

// ----------------------------------------
// Register indices on the plain port
// ----------------------------------------
`define PTRD_IDX_DIVISOR 3'h0
`define PTRD_IDX_OSCSEL 3'h1
`define PTRD_IDX_PLLMUL 3'h2
`define PTRD_IDX_TRIM 3'h3
`define PTRD_IDX_REFO 3'h4

// ----------------------------------------
// Write masks and reset values
// ----------------------------------------
`define PTRD_DIVISOR_MASK 16'hFFDF
`define PTRD_DIVISOR_RST 16'h0100
`define PTRD_OSCSEL_RST 3'h0
`define PTRD_PLLMUL_RST 9'h030
`define PTRD_TRIM_RST 6'h00
`define PTRD_REFO_MASK 16'hBF00
`define PTRD_REFO_RST 16'h0000
`define PTRD_ZERO16 16'h0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PTRD_WAKE_BIT 15
`define PTRD_DOZE_HI 14
`define PTRD_DOZE_LO 12
`define PTRD_SLOW_EN_BIT 11
`define PTRD_OSCSEL_HI 10
`define PTRD_OSCSEL_LO 8
`define PTRD_DIVISOR_RSV_BIT 5
`define PTRD_PLL_HI 8
`define PTRD_PLL_LO 0
`define PTRD_TRIM_HI 5
`define PTRD_TRIM_LO 0
`define PTRD_REF_ON_BIT 15
`define PTRD_REF_SLP_BIT 13
`define PTRD_REF_SEL_BIT 12
`define PTRD_REF_DIV_HI 11
`define PTRD_REF_DIV_LO 8

// ----------------------------------------
// Field values
// ----------------------------------------
`define PTRD_DOZE_OFF 3'h0
`define PTRD_PLL_OFFSET 10'h002
`define PTRD_DIV_BYPASS 4'h0
`define PTRD_DIV_ONE 4'h1
`define PTRD_CNT_ONE 15'h0001
`define PTRD_CNT_ZERO 15'h0000

`endif

/* ptrd_pkg.sv */
// Types shared by the clock-control register block.
// Assumes nothing of its surroundings.
package ptrd_pkg;
	typedef logic [2:0] ptrd_addr_type;
	typedef logic [15:0] ptrd_data_type;
	typedef logic [14:0] ptrd_count_type;
endpackage : ptrd_pkg

/* ptrd_sync2.sv */
// Two-stage synchroniser for a level arriving from outside the mclk domain.
// Assumes a single clock and a synchronous active-low reset.
`include "ptrd_consts.svh"
module ptrd_sync2
	import ptrd_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic d,
	output logic q
);
	logic meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			meta_reg <= 1'b0;
			q <= 1'b0;
		end else if (ce) begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule : ptrd_sync2

/* ptrd_ref_div.sv */
// Reference clock divider: power-of-two division of the chosen source.
// Assumes the crystal input has already been synchronised to mclk.
`include "ptrd_consts.svh"
module ptrd_ref_div
	import ptrd_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic run,
	input wire logic src_sel,
	input wire logic [3:0] div_sel,
	input wire logic xtal_sync,
	output logic ref_q
);
	logic xtal_d_reg;
	ptrd_count_type cnt_reg;
	ptrd_count_type half_count;
	logic tick;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			xtal_d_reg <= 1'b0;
		end else if (ce) begin
			xtal_d_reg <= xtal_sync;
		end
	end

	// Undivided crystal toggles on both edges, so it follows the source.
	// Undivided system clock can only reach mclk/2 from a flip-flop.
	always_comb begin
		if (div_sel == `PTRD_DIV_BYPASS) begin
			tick = src_sel ? (xtal_sync ^ xtal_d_reg) : 1'b1;
			half_count = `PTRD_CNT_ZERO;
		end else begin
			tick = src_sel ? (xtal_sync & ~xtal_d_reg) : 1'b1;
			half_count = (`PTRD_CNT_ONE << (div_sel - `PTRD_DIV_ONE)) - `PTRD_CNT_ONE;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst || (ce && !run)) begin
			cnt_reg <= `PTRD_CNT_ZERO;
			ref_q <= 1'b0;
		end else if (ce && tick) begin
			if (cnt_reg >= half_count) begin
				cnt_reg <= `PTRD_CNT_ZERO;
				ref_q <= ~ref_q;
			end else begin
				cnt_reg <= cnt_reg + `PTRD_CNT_ONE;
			end
		end
	end
endmodule : ptrd_ref_div

/* ptrd_clock_ctrl.sv */
// Clock-control registers: CPU slowdown guards, PLL multiplier, fast RC trim
// and the reference clock output generator.
// Assumes mclk at 10 MHz, nrst as power-on reset, sys_rst_n as any other
// reset, and a register master on the same clock that never waits.
//
// Overview of operation
// - Slowdown ratio writes ignored while slowdown enable is set.
// - Setting slowdown enable ignored when ratio field is zero.
// - Interrupt with wake bit set clears slowdown enable.
// - Clock divisor register resets only on power-on reset.
// - PLL feedback and trim registers reset only on power-on reset.
// - PLL multiplier equals nine-bit field plus two.
// - PLL field resets to pattern giving multiplier fifty.
// - Six-bit trim drives fast RC oscillator, zero is centre.
// - Trim is two's complement, 011111 highest, 100000 lowest.
// - Reference clock pin driven only while output enable set.
// - Reference output stops in sleep unless run-in-sleep set.
// - Source select: one picks crystal, zero picks system clock.
// - Reference divider divides by two to the field value; field zero on the system clock gives mclk/2.
// - New oscillator selection accepted only while not locked.
// - Slowdown ratio is two to the field, 1:1 by default.
//
// Decided for this implementation: the placing of the registers and the plain strobed port.
`include "ptrd_consts.svh"
module ptrd_clock_ctrl
	import ptrd_pkg::*;
(
	input wire logic mclk,
	input wire logic nrst,
	input wire logic ce,
	input wire logic sys_rst_n,
	input wire ptrd_addr_type reg_addr,
	input wire ptrd_data_type reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output ptrd_data_type reg_rdata,
	input wire logic irq_event,
	input wire logic sleep_mode,
	input wire logic clk_config_locked,
	input wire logic xtal_clk_pin,
	output logic [2:0] doze_ratio_sel,
	output logic [9:0] pll_multiplier,
	output logic [5:0] rc_trim_code,
	output logic [2:0] new_oscillator_select,
	output logic output_pin_a,
	output logic output_pin_a_oe
);
	// ----------------------------------------
	// Register state
	// ----------------------------------------
	ptrd_data_type clock_divisor_register_reg;
	ptrd_data_type clock_divisor_register_next;
	logic [2:0] oscsel_reg;
	logic [8:0] pll_feedback_register_reg;
	logic [5:0] rc_trim_register_reg;
	ptrd_data_type output_pin_a_control_register_reg;
	logic wr_divisor;
	logic wr_oscsel;
	logic wr_pll;
	logic wr_trim;
	logic wr_refo;
	logic cpu_slowdown_enable;
	logic wake_full_speed_on_irq;
	logic [2:0] slowdown_ratio;
	logic output_pin_a_output_enable;
	logic output_pin_a_run_in_sleep;
	logic output_pin_a_source_select;
	logic [3:0] output_pin_a_divider_field;
	logic output_pin_a_run;
	logic xtal_sync;
	logic ref_q;
	ptrd_data_type read_mux;

	assign wr_divisor = ce && reg_wr && (reg_addr == `PTRD_IDX_DIVISOR);
	assign wr_oscsel = ce && reg_wr && (reg_addr == `PTRD_IDX_OSCSEL);
	assign wr_pll = ce && reg_wr && (reg_addr == `PTRD_IDX_PLLMUL);
	assign wr_trim = ce && reg_wr && (reg_addr == `PTRD_IDX_TRIM);
	assign wr_refo = ce && reg_wr && (reg_addr == `PTRD_IDX_REFO);

	assign cpu_slowdown_enable = clock_divisor_register_reg[`PTRD_SLOW_EN_BIT];
	assign wake_full_speed_on_irq = clock_divisor_register_reg[`PTRD_WAKE_BIT];
	assign slowdown_ratio = clock_divisor_register_reg[`PTRD_DOZE_HI:`PTRD_DOZE_LO];
	assign output_pin_a_output_enable = output_pin_a_control_register_reg[`PTRD_REF_ON_BIT];
	assign output_pin_a_run_in_sleep = output_pin_a_control_register_reg[`PTRD_REF_SLP_BIT];
	assign output_pin_a_source_select = output_pin_a_control_register_reg[`PTRD_REF_SEL_BIT];
	assign output_pin_a_divider_field =
		output_pin_a_control_register_reg[`PTRD_REF_DIV_HI:`PTRD_REF_DIV_LO];

	// ----------------------------------------
	// Clock divisor register
	// ----------------------------------------
	always_comb begin
		clock_divisor_register_next = clock_divisor_register_reg;
		if (wr_divisor) begin
			clock_divisor_register_next = reg_wdata & `PTRD_DIVISOR_MASK;
			if (cpu_slowdown_enable) begin
				clock_divisor_register_next[`PTRD_DOZE_HI:`PTRD_DOZE_LO] = slowdown_ratio;
			end
			if (clock_divisor_register_next[`PTRD_DOZE_HI:`PTRD_DOZE_LO] == `PTRD_DOZE_OFF) begin
				clock_divisor_register_next[`PTRD_SLOW_EN_BIT] = 1'b0;
			end
		end
		// Interrupt wakes full speed; beats a software set in the same cycle
		if (irq_event && wake_full_speed_on_irq) begin
			clock_divisor_register_next[`PTRD_SLOW_EN_BIT] = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			clock_divisor_register_reg <= `PTRD_DIVISOR_RST;
		end else if (ce) begin
			clock_divisor_register_reg <= clock_divisor_register_next;
		end
	end

	// ----------------------------------------
	// New oscillator selection
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			oscsel_reg <= `PTRD_OSCSEL_RST;
		end else if (wr_oscsel && !clk_config_locked) begin
			oscsel_reg <= reg_wdata[`PTRD_OSCSEL_HI:`PTRD_OSCSEL_LO];
		end
	end

	// ----------------------------------------
	// PLL feedback and fast RC trim
	// ----------------------------------------
	// Kept across other resets
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pll_feedback_register_reg <= `PTRD_PLLMUL_RST;
		end else if (wr_pll) begin
			pll_feedback_register_reg <= reg_wdata[`PTRD_PLL_HI:`PTRD_PLL_LO];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			rc_trim_register_reg <= `PTRD_TRIM_RST;
		end else if (wr_trim) begin
			rc_trim_register_reg <= reg_wdata[`PTRD_TRIM_HI:`PTRD_TRIM_LO];
		end
	end

	// ----------------------------------------
	// Reference clock control
	// ----------------------------------------
	// Cleared by every reset source, unlike the registers above.
	// The divider follows a field change at once; software is expected
	// to stop the output first, so no glitch guard is built here.
	always_ff @(posedge mclk) begin
		if (!nrst || !sys_rst_n) begin
			output_pin_a_control_register_reg <= `PTRD_REFO_RST;
		end else if (wr_refo) begin
			output_pin_a_control_register_reg <= reg_wdata & `PTRD_REFO_MASK;
		end
	end

	assign output_pin_a_run = output_pin_a_output_enable && (!sleep_mode || output_pin_a_run_in_sleep);

	ptrd_sync2 u_xtal_sync (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.d(xtal_clk_pin),
		.q(xtal_sync)
	);

	ptrd_ref_div u_ref_div (
		.mclk(mclk),
		.nrst(nrst),
		.ce(ce),
		.run(output_pin_a_run),
		.src_sel(output_pin_a_source_select),
		.div_sel(output_pin_a_divider_field),
		.xtal_sync(xtal_sync),
		.ref_q(ref_q)
	);

	assign output_pin_a = ref_q;

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			output_pin_a_oe <= 1'b0;
		end else if (ce) begin
			output_pin_a_oe <= output_pin_a_run;
		end
	end

	// ----------------------------------------
	// Control outputs
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			doze_ratio_sel <= `PTRD_DOZE_OFF;
			pll_multiplier <= `PTRD_PLL_OFFSET;
			rc_trim_code <= `PTRD_TRIM_RST;
			new_oscillator_select <= `PTRD_OSCSEL_RST;
		end else if (ce) begin
			doze_ratio_sel <= cpu_slowdown_enable ? slowdown_ratio : `PTRD_DOZE_OFF;
			pll_multiplier <= {1'b0, pll_feedback_register_reg} + `PTRD_PLL_OFFSET;
			rc_trim_code <= rc_trim_register_reg;
			new_oscillator_select <= oscsel_reg;
		end
	end

	// ----------------------------------------
	// Register read port
	// ----------------------------------------
	always_comb begin
		read_mux = `PTRD_ZERO16;
		case (reg_addr)
			`PTRD_IDX_DIVISOR: read_mux = clock_divisor_register_reg;
			`PTRD_IDX_OSCSEL: read_mux[`PTRD_OSCSEL_HI:`PTRD_OSCSEL_LO] = oscsel_reg;
			`PTRD_IDX_PLLMUL: read_mux[`PTRD_PLL_HI:`PTRD_PLL_LO] = pll_feedback_register_reg;
			`PTRD_IDX_TRIM: read_mux[`PTRD_TRIM_HI:`PTRD_TRIM_LO] = rc_trim_register_reg;
			`PTRD_IDX_REFO: read_mux = output_pin_a_control_register_reg;
			default: read_mux = `PTRD_ZERO16;
		endcase
	end

	// Data stand only in the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			reg_rdata <= `PTRD_ZERO16;
		end else if (ce) begin
			reg_rdata <= reg_rd ? read_mux : `PTRD_ZERO16;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence pin_stops_s;
		!output_pin_a_oe && !output_pin_a;
	endsequence

	sequence stopped_run_s;
		ce && !output_pin_a_run;
	endsequence

	doze_ratio_guard_a: assert property (
		wr_divisor && cpu_slowdown_enable |=> $stable(slowdown_ratio))
		else $error("slowdown ratio changed while slowdown enabled");

	doze_enable_block_a: assert property (
		cpu_slowdown_enable |-> slowdown_ratio != `PTRD_DOZE_OFF)
		else $error("slowdown enabled with zero ratio");

	irq_wake_a: assert property (
		ce && irq_event && wake_full_speed_on_irq |=> !cpu_slowdown_enable ##1
			doze_ratio_sel == `PTRD_DOZE_OFF)
		else $error("interrupt did not restore full speed");

	divisor_por_only_a: assert property (
		!sys_rst_n && !wr_divisor && !irq_event |=> $stable(clock_divisor_register_reg))
		else $error("clock divisor register changed on other reset");

	pll_trim_keep_a: assert property (
		!sys_rst_n && !reg_wr |=> $stable(pll_feedback_register_reg) &&
			$stable(rc_trim_register_reg))
		else $error("pll or trim register changed on other reset");

	pll_mult_value_a: assert property (
		ce && $stable(pll_feedback_register_reg) |=>
			pll_multiplier == {1'b0, $past(pll_feedback_register_reg)} + `PTRD_PLL_OFFSET)
		else $error("pll multiplier not field plus two");

	pll_reset_value_a: assert property (
		$rose(nrst) |-> pll_feedback_register_reg == `PTRD_PLLMUL_RST)
		else $error("pll field reset value wrong");

	trim_follows_a: assert property (
		ce ##1 ce |-> rc_trim_code == $past(rc_trim_register_reg))
		else $error("trim output lags register");

	pin_disable_a: assert property (
		stopped_run_s ##1 stopped_run_s |-> pin_stops_s)
		else $error("reference pin driven while disabled");

	sleep_stop_a: assert property (
		ce && sleep_mode && !output_pin_a_run_in_sleep |=> !output_pin_a_oe)
		else $error("reference output running in sleep");

	osc_lock_a: assert property (
		clk_config_locked |=> $stable(oscsel_reg))
		else $error("oscillator selection changed while locked");

	doze_out_a: assert property (
		ce && !cpu_slowdown_enable |=> doze_ratio_sel == `PTRD_DOZE_OFF)
		else $error("ratio not 1:1 while slowdown off");

	reserved_zero_a: assert property (
		(output_pin_a_control_register_reg & ~`PTRD_REFO_MASK) == `PTRD_ZERO16 &&
			clock_divisor_register_reg[`PTRD_DIVISOR_RSV_BIT] == 1'b0)
		else $error("reserved bit set");
endmodule : ptrd_clock_ctrl

/* ptrd_xtal_model.sv */
// Crystal source that stands on the crystal pin of the clock-control block.
// Assumes the bench clock runs well above twice the crystal rate.
module ptrd_xtal_model #(
	parameter int HALF_NS = 500
) (
	output logic xtal_clk_pin
);
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Free-running crystal
	// ----------------------------------------
	// Odd start offset keeps its phase unrelated to mclk
	initial begin
		xtal_clk_pin = 1'b0;
		#237;
		forever #HALF_NS xtal_clk_pin = ~xtal_clk_pin;
	end
endmodule : ptrd_xtal_model

/* testbench.sv */
// Self-checking bench for the clock-control register block.
// Assumes ptrd_pkg, the design files and the crystal model are compiled first.
`include "ptrd_consts.svh"
module testbench
	import ptrd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk, nrst, sys_rst_n, reg_wr, reg_rd, irq_event, sleep_mode, clk_config_locked;
	logic ce;
	logic xtal_clk_pin, output_pin_a, output_pin_a_oe;
	ptrd_addr_type reg_addr;
	ptrd_data_type reg_wdata, reg_rdata, ref_now;
	logic [2:0] doze_ratio_sel, new_oscillator_select;
	logic [9:0] pll_multiplier;
	logic [5:0] rc_trim_code;
	int miscompares = 0;
	int check_count = 0;
	int edges;

	ptrd_xtal_model xtal (.xtal_clk_pin(xtal_clk_pin));

	ptrd_clock_ctrl dut (.mclk(mclk), .nrst(nrst), .ce(ce), .sys_rst_n(sys_rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq_event(irq_event), .sleep_mode(sleep_mode),
		.clk_config_locked(clk_config_locked), .xtal_clk_pin(xtal_clk_pin),
		.doze_ratio_sel(doze_ratio_sel), .pll_multiplier(pll_multiplier),
		.rc_trim_code(rc_trim_code), .new_oscillator_select(new_oscillator_select),
		.output_pin_a(output_pin_a), .output_pin_a_oe(output_pin_a_oe));

	// ----------------------------------------
	// Bench tasks
	// ----------------------------------------
	task automatic close_out();
		if (miscompares == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	task automatic check(input string what, input ptrd_data_type seen, input ptrd_data_type exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	task automatic wr(input ptrd_addr_type a, input ptrd_data_type d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input ptrd_addr_type a, input ptrd_data_type exp);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		check($sformatf("register %0d", a), reg_rdata, exp);
	endtask : rd

	// Derived outputs trail a write by two cycles
	task automatic settle();
		repeat (3) @(posedge mclk);
		#1;
	endtask : settle

	task automatic irq_pulse();
		@(posedge mclk);
		irq_event <= 1'b1;
		@(posedge mclk);
		irq_event <= 1'b0;
		settle();
	endtask : irq_pulse

	task automatic set_ref(input ptrd_data_type v);
		wr(`PTRD_IDX_REFO, ref_now & 16'h7FFF);
		wr(`PTRD_IDX_REFO, v & 16'h7FFF);
		wr(`PTRD_IDX_REFO, v);
		ref_now = v;
		settle();
	endtask : set_ref

	task automatic count_rises(input int cycles);
		logic prev;
		edges = 0;
		prev = output_pin_a;
		repeat (cycles) begin
			@(posedge mclk);
			#1;
			if (output_pin_a === 1'b1 && prev === 1'b0) edges++;
			prev = output_pin_a;
		end
	endtask : count_rises

	// ----------------------------------------
	// Clock and watchdog
	// ----------------------------------------
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Whole sequence needs about 900 cycles
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		close_out();
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		nrst = 1'b0;
		sys_rst_n = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		irq_event = 1'b0;
		sleep_mode = 1'b0;
		clk_config_locked = 1'b0;
		ce = 1'b1;
		ref_now = '0;
		repeat (8) @(posedge mclk);
		nrst <= 1'b1;
		settle();
		rd(`PTRD_IDX_DIVISOR, 16'h0100);
		rd(`PTRD_IDX_PLLMUL, 16'h0030);
		rd(`PTRD_IDX_TRIM, 16'h0000);
		rd(`PTRD_IDX_REFO, 16'h0000);
		rd(3'h5, 16'h0000);
		check("pll multiplier", {6'h0, pll_multiplier}, 16'h0032);
		wr(`PTRD_IDX_PLLMUL, 16'hFFFF);
		settle();
		check("pll multiplier", {6'h0, pll_multiplier}, 16'h0201);
		rd(`PTRD_IDX_PLLMUL, 16'h01FF);
		wr(`PTRD_IDX_PLLMUL, 16'h0000);
		settle();
		check("pll multiplier", {6'h0, pll_multiplier}, 16'h0002);
		// Clock enable low: the write strobe must be ignored
		@(posedge mclk);
		ce <= 1'b0;
		wr(`PTRD_IDX_PLLMUL, 16'h0055);
		ce <= 1'b1;
		rd(`PTRD_IDX_PLLMUL, 16'h0000);
		wr(`PTRD_IDX_TRIM, 16'hFFE0);
		settle();
		check("trim code", {10'h0, rc_trim_code}, 16'h0020);
		rd(`PTRD_IDX_TRIM, 16'h0020);
		wr(`PTRD_IDX_TRIM, 16'h001F);
		settle();
		check("trim code", {10'h0, rc_trim_code}, 16'h001F);
		wr(`PTRD_IDX_DIVISOR, 16'h0800);
		rd(`PTRD_IDX_DIVISOR, 16'h0000);
		wr(`PTRD_IDX_DIVISOR, 16'h3800);
		settle();
		check("slowdown ratio", {13'h0, doze_ratio_sel}, 16'h0003);
		wr(`PTRD_IDX_DIVISOR, 16'h7800);
		irq_pulse();
		rd(`PTRD_IDX_DIVISOR, 16'h3800);
		wr(`PTRD_IDX_DIVISOR, 16'h3000);
		wr(`PTRD_IDX_DIVISOR, 16'hF800);
		settle();
		check("slowdown ratio", {13'h0, doze_ratio_sel}, 16'h0007);
		irq_pulse();
		rd(`PTRD_IDX_DIVISOR, 16'hF000);
		check("slowdown ratio", {13'h0, doze_ratio_sel}, 16'h0000);
		wr(`PTRD_IDX_OSCSEL, 16'h0500);
		settle();
		check("oscillator select", {13'h0, new_oscillator_select}, 16'h0005);
		@(posedge mclk);
		clk_config_locked <= 1'b1;
		wr(`PTRD_IDX_OSCSEL, 16'h0300);
		settle();
		check("oscillator select", {13'h0, new_oscillator_select}, 16'h0005);
		wr(`PTRD_IDX_REFO, 16'h7FFF);
		rd(`PTRD_IDX_REFO, 16'h3F00);
		check("pin enable", 16'(output_pin_a_oe), 16'h0000);
		ref_now = 16'h3F00;
		for (int n = 1; n <= 6; n++) begin
			set_ref(16'h8000 | 16'(n << 8));
			check("pin enable", 16'(output_pin_a_oe), 16'h0001);
			count_rises(64);
			check("ref rising edges", 16'(edges), 16'(64 >> n));
		end
		// Crystal at ten mclk periods, divided by two
		set_ref(16'h9100);
		count_rises(200);
		check("crystal rising edges", 16'(edges), 16'h000A);
		@(posedge mclk);
		sleep_mode <= 1'b1;
		settle();
		check("pin enable", 16'(output_pin_a_oe), 16'h0000);
		count_rises(64);
		check("sleep rising edges", 16'(edges), 16'h0000);
		check("pin level", 16'(output_pin_a), 16'h0000);
		set_ref(16'hA100);
		count_rises(64);
		check("sleep rising edges", 16'(edges), 16'h0020);
		@(posedge mclk);
		sleep_mode <= 1'b0;
		sys_rst_n <= 1'b0;
		@(posedge mclk);
		sys_rst_n <= 1'b1;
		settle();
		ref_now = '0;
		check("pin enable", 16'(output_pin_a_oe), 16'h0000);
		rd(`PTRD_IDX_REFO, 16'h0000);
		rd(`PTRD_IDX_DIVISOR, 16'hF000);
		rd(`PTRD_IDX_TRIM, 16'h001F);
		rd(`PTRD_IDX_PLLMUL, 16'h0000);
		@(posedge mclk);
		nrst <= 1'b0;
		@(posedge mclk);
		nrst <= 1'b1;
		settle();
		rd(`PTRD_IDX_DIVISOR, 16'h0100);
		rd(`PTRD_IDX_TRIM, 16'h0000);
		rd(`PTRD_IDX_PLLMUL, 16'h0030);
		close_out();
	end
endmodule : testbench
